// ---- rtl/dmc_pkg.sv ----
package dmc_pkg;
   // clock and timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned RETRY_BASE_MS = 10;
   localparam int unsigned RETRY_BASE_CYCLES = RETRY_BASE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned SYNC_PERIOD_NS = 5000;
   localparam int unsigned LOW_RESET_CYCLES = (2 * SYNC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RETRIES_PER_STAGE = 8;
   localparam logic [1:0] LAST_STAGE = 2'h3;
   localparam int unsigned TIMER_W = 24;
   localparam int unsigned LOWCNT_W = 11;

   // register byte addresses
   localparam logic [7:0] ADDR_HWCTRL = 8'h00;
   localparam logic [7:0] ADDR_OUTEN = 8'h04;
   localparam logic [7:0] ADDR_LATCHCLR = 8'h08;
   localparam logic [7:0] ADDR_OLCFG = 8'h0c;
   localparam logic [7:0] ADDR_MAP = 8'h10;
   localparam logic [7:0] ADDR_DIAG = 8'h14;
   localparam logic [7:0] ADDR_INPUT_STATUS_WORD = 8'h18;
   localparam logic [7:0] ADDR_MONITOR = 8'h1c;

   // field positions
   localparam int unsigned HW_ACT_BIT = 0;
   localparam int unsigned HW_PWM_LSB = 1;
   localparam int unsigned MAP_A_LSB = 0;
   localparam int unsigned MAP_B_LSB = 4;
   localparam int unsigned DIAG_UV_BIT = 0;
   localparam int unsigned DIAG_LOP_BIT = 1;
   localparam int unsigned DIAG_MODE_LSB = 2;
   localparam int unsigned DIAG_TER_BIT = 4;
   localparam int unsigned DIAG_OPEN_LOAD_ON_FLAG_BIT = 5;
   localparam int unsigned DIAG_OPEN_LOAD_OFF_FLAG_BIT = 6;
   localparam int unsigned DIAG_ERR_LSB = 8;
   localparam int unsigned INPUT_STATUS_WORD_TER_BIT = 0;
   localparam int unsigned INPUT_STATUS_WORD_INA_BIT = 1;
   localparam int unsigned INPUT_STATUS_WORD_INB_BIT = 2;

   // reset values and fixed channels
   localparam logic [2:0] MAP_A_RST = 3'h2;
   localparam logic [2:0] MAP_B_RST = 3'h3;
   localparam int unsigned LIMP_CH_A = 2;
   localparam int unsigned LIMP_CH_B = 3;

   typedef enum logic [1:0] {MODE_SLEEP, MODE_IDLE, MODE_ACTIVE, MODE_LIMP} dmc_mode_t;
endpackage

// ---- rtl/dmc_mode_ctrl.sv ----
// How it works
// - idle pin and both inputs low: sleep, outputs off, registers to defaults.
// - idle pin high, inputs low: idle, channels off, open-load source off.
// - in idle, registers and serial access only with logic supply good.
// - overload and overtemperature flags survive going from active to idle.
// - idle pin high plus either input high enters active.
// - idle pin high plus activate, output or pwm enable write enters active.
// - each active entry restores input a to channel 2, b to 3.
// - idle pin low with an input high is limp home, channels 2/3 only.
// - in limp home input a drives channel 2, input b channel 3.
// - limp home pin control works right after power-up, unconfigured.
// - limp home serial access is read-only, faults and monitor still reported.
// - limp home keeps the open-load current source off on every channel.
// - limp entry sets undervoltage and low-logic flags, clears open-load flags.
// - first response after limp entry is the input word with error set.
// - limp retries: eight at 10 ms, eight at 20, eight at 40, then 80.
// - the initial turn-on attempt is not counted as a retry.
// - input low two sync periods restarts the schedule at 10 ms.
// - power-on starts when either supply-good indication asserts.
// - both supplies bad: channels off, serial blocked, registers held reset.
// - low-logic flag stays set until the diagnostic word is read.
// - channel error clears by latch-clear write or in sleep; the latch-clear then self-clears.
`timescale 1ns/10ps
`default_nettype none
module dmc_mode_ctrl
#(
   parameter int unsigned RetryBaseCycles = dmc_pkg::RETRY_BASE_CYCLES // 10 ms stage interval
)
(
   input wire logic ref_clk, // system clock
   input wire logic rst, // synchronous reset, high
   input wire logic clkEn, // freezes all state when low, except the sleep-mode register clear
   input wire logic idlePin, // idle-control pin, async
   input wire logic directInputA, // direct input a pin, async
   input wire logic directInputB, // direct input b pin, async
   input wire logic vsGood, // battery supply above undervoltage, async
   input wire logic vddGood, // logic supply above undervoltage, async
   input wire logic [7:0] channelFault, // overload/short/overtemp trip per channel
   input wire logic [7:0] outputMonitor, // output status monitor per channel
   input wire logic openLoadOnDet, // open load at on detected, pulse
   input wire logic openLoadOffDet, // open load at off detected, pulse
   input wire logic frameError, // serial frame error, pulse
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output var logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   output var logic [7:0] channelOn, // channel drive
   output var logic [7:0] openLoadSourceEn, // open-load diagnostic current
   output var dmc_pkg::dmc_mode_t mode // current operating mode
);
   import dmc_pkg::*;

   // map index to one-hot channel select
   function automatic logic [7:0] chanSel(input logic [2:0] idx);
      logic [7:0] s;
      s = 8'h00;
      s[idx] = 1'b1;
      return s;
   endfunction

   logic [4:0] syncMeta;
   logic [4:0] syncOut;
   logic idleS;
   logic inAS;
   logic inBS;
   logic vsS;
   logic vddS;
   logic powered;
   dmc_mode_t prevMode;
   dmc_mode_t next_mode;
   logic enterActive;
   logic enterLimp;
   logic regClear;
   logic activateBit;
   logic [1:0] pwmEnable;
   logic [7:0] outEnable;
   logic [7:0] latchClear;
   logic [7:0] olConfig;
   logic [2:0] mapA;
   logic [2:0] mapB;
   logic [7:0] errFlag;
   logic battUvFlag;
   logic lowLogicFlag;
   logic olOnFlag;
   logic olOffFlag;
   logic terFlag;
   logic firstRespPending;
   logic respWasInst;
   logic [1:0] limpTrip;
   logic mapped;
   logic writeOk;
   logic readOk;
   logic accessDone;
   logic wrDone;
   logic rdDone;
   logic [31:0] instWord;
   logic [31:0] diagWord;
   logic [31:0] next_prdata;
   logic [7:0] activeOn;

   // two flops per async pin; only the second stage is read
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         syncMeta <= 5'h00;
         syncOut <= 5'h00;
      end
      else if (clkEn)
      begin
         syncMeta <= {vddGood, vsGood, directInputB, directInputA, idlePin};
         syncOut <= syncMeta;
      end
   end
   assign idleS = syncOut[0];
   assign inAS = syncOut[1];
   assign inBS = syncOut[2];
   assign vsS = syncOut[3];
   assign vddS = syncOut[4];
   assign powered = vsS | vddS;

   // mode decode from synchronised pins and activation bits
   always_comb
   begin
      if (!powered)
         next_mode = MODE_SLEEP;
      else if (!idleS && !(inAS || inBS))
         next_mode = MODE_SLEEP;
      else if (!idleS)
         next_mode = MODE_LIMP;
      else if (inAS || inBS)
         next_mode = MODE_ACTIVE;
      else if (activateBit || (|outEnable) || (|pwmEnable))
         next_mode = MODE_ACTIVE;
      else
         next_mode = MODE_IDLE;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         mode <= MODE_SLEEP;
         prevMode <= MODE_SLEEP;
      end
      else if (clkEn)
      begin
         mode <= next_mode;
         prevMode <= mode;
      end
   end
   assign enterActive = (mode == MODE_ACTIVE) && (prevMode != MODE_ACTIVE);
   assign enterLimp = (mode == MODE_LIMP) && (prevMode != MODE_LIMP);
   // sleep also covers both supplies bad, so one clear term serves both
   assign regClear = (mode == MODE_SLEEP);

   // bus gating by mode and supply; zero wait states
   always_comb
   begin
      case (paddr)
         ADDR_HWCTRL, ADDR_OUTEN, ADDR_LATCHCLR, ADDR_OLCFG, ADDR_MAP, ADDR_DIAG, ADDR_INPUT_STATUS_WORD, ADDR_MONITOR:
            mapped = 1'b1;
         default:
            mapped = 1'b0;
      endcase
   end
   assign readOk = vddS && (mode != MODE_SLEEP);
   assign writeOk = vddS && idleS && ((mode == MODE_IDLE) || (mode == MODE_ACTIVE));
   assign pready = psel && penable && clkEn;
   assign pslverr = pready && (!mapped || !readOk || (pwrite && !writeOk));
   assign accessDone = pready && !pslverr;
   assign wrDone = accessDone && pwrite;
   assign rdDone = accessDone && !pwrite;

   // software control bits; writes land only in idle or active
   always_ff @(posedge ref_clk)
   begin
      if (rst || regClear)
      begin
         activateBit <= 1'b0;
         pwmEnable <= 2'h0;
         outEnable <= 8'h00;
         olConfig <= 8'h00;
      end
      else if (clkEn && wrDone)
      begin
         if (paddr == ADDR_HWCTRL)
         begin
            activateBit <= pwdata[HW_ACT_BIT];
            pwmEnable <= pwdata[HW_PWM_LSB +: 2];
         end
         if (paddr == ADDR_OUTEN)
            outEnable <= pwdata[7:0];
         if (paddr == ADDR_OLCFG)
            olConfig <= pwdata[7:0];
      end
   end

   // input routing; every active entry restores the default map
   always_ff @(posedge ref_clk)
   begin
      if (rst || regClear || (clkEn && enterActive))
      begin
         mapA <= MAP_A_RST;
         mapB <= MAP_B_RST;
      end
      else if (clkEn && wrDone && (paddr == ADDR_MAP))
      begin
         mapA <= pwdata[MAP_A_LSB +: 3];
         mapB <= pwdata[MAP_B_LSB +: 3];
      end
   end

   // error latch: a trip sets, latch-clear releases, trip wins the tie
   always_ff @(posedge ref_clk)
   begin
      if (rst || regClear)
      begin
         errFlag <= 8'h00;
         latchClear <= 8'h00;
      end
      else if (clkEn)
      begin
         errFlag <= (errFlag & ~(latchClear & ~channelFault)) | (channelFault & channelOn);
         if (wrDone && (paddr == ADDR_LATCHCLR))
            latchClear <= (latchClear & errFlag) | pwdata[7:0];
         else
            latchClear <= latchClear & errFlag;
      end
   end

   // diagnostic flags; hardware set beats the read clear
   always_ff @(posedge ref_clk)
   begin
      if (rst || regClear)
      begin
         battUvFlag <= 1'b1;
         lowLogicFlag <= 1'b1;
         olOnFlag <= 1'b0;
         olOffFlag <= 1'b0;
      end
      else if (clkEn)
      begin
         if (enterLimp || !vsS)
            battUvFlag <= 1'b1;
         else if (rdDone && (paddr == ADDR_DIAG) && !respWasInst)
            battUvFlag <= 1'b0;
         if (enterLimp || !vddS)
            lowLogicFlag <= 1'b1;
         else if (rdDone && (paddr == ADDR_DIAG) && !respWasInst)
            lowLogicFlag <= 1'b0;
         if (enterLimp)
         begin
            olOnFlag <= 1'b0;
            olOffFlag <= 1'b0;
         end
         else
         begin
            if (openLoadOnDet && (mode == MODE_ACTIVE))
               olOnFlag <= 1'b1;
            else if (rdDone && (paddr == ADDR_DIAG) && !respWasInst)
               olOnFlag <= 1'b0;
            if (openLoadOffDet && (mode == MODE_ACTIVE))
               olOffFlag <= 1'b1;
            else if (rdDone && (paddr == ADDR_DIAG) && !respWasInst)
               olOffFlag <= 1'b0;
         end
      end
   end

   // transmission error and the forced input-word answer after limp entry
   always_ff @(posedge ref_clk)
   begin
      if (rst || regClear)
      begin
         terFlag <= 1'b1;
         firstRespPending <= 1'b1;
      end
      else if (clkEn)
      begin
         if (frameError)
            terFlag <= 1'b1;
         else if (rdDone && ((paddr == ADDR_INPUT_STATUS_WORD) || respWasInst))
            terFlag <= 1'b0;
         if (enterLimp)
            firstRespPending <= 1'b1;
         else if (accessDone)
            firstRespPending <= 1'b0;
      end
   end

   // read words; the answer is built in the setup cycle
   always_comb
   begin
      instWord = 32'h00000000;
      instWord[INPUT_STATUS_WORD_TER_BIT] = terFlag || firstRespPending;
      instWord[INPUT_STATUS_WORD_INA_BIT] = inAS;
      instWord[INPUT_STATUS_WORD_INB_BIT] = inBS;
      diagWord = 32'h00000000;
      diagWord[DIAG_UV_BIT] = battUvFlag;
      diagWord[DIAG_LOP_BIT] = lowLogicFlag;
      diagWord[DIAG_MODE_LSB +: 2] = mode;
      diagWord[DIAG_TER_BIT] = terFlag;
      diagWord[DIAG_OPEN_LOAD_ON_FLAG_BIT] = olOnFlag;
      diagWord[DIAG_OPEN_LOAD_OFF_FLAG_BIT] = olOffFlag;
      diagWord[DIAG_ERR_LSB +: 8] = errFlag;
      next_prdata = 32'h00000000;
      if (firstRespPending)
         next_prdata = instWord;
      else
         case (paddr)
            ADDR_HWCTRL: next_prdata = {29'h00000000, pwmEnable, activateBit};
            ADDR_OUTEN: next_prdata = {24'h000000, outEnable};
            ADDR_LATCHCLR: next_prdata = {24'h000000, latchClear};
            ADDR_OLCFG: next_prdata = {24'h000000, olConfig};
            ADDR_MAP: next_prdata = {25'h0000000, mapB, 1'b0, mapA};
            ADDR_DIAG: next_prdata = diagWord;
            ADDR_INPUT_STATUS_WORD: next_prdata = instWord;
            ADDR_MONITOR: next_prdata = {24'h000000, outputMonitor};
            default: next_prdata = 32'h00000000;
         endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         prdata <= 32'h00000000;
         respWasInst <= 1'b0;
      end
      else if (clkEn && psel && !penable)
      begin
         prdata <= (readOk && mapped) ? next_prdata : 32'h00000000;
         respWasInst <= firstRespPending;
      end
   end

   // limp-home auto-retry, one engine each for channels 2 and 3
   generate
      for (genvar k = 0; k < 2; k++)
      begin : limpRetry
         logic pinS;
         logic fault;
         logic [1:0] stage;
         logic [2:0] retryCnt;
         logic [TIMER_W-1:0] timer;
         logic [LOWCNT_W-1:0] lowCnt;
         assign pinS = (k == 0) ? inAS : inBS;
         assign fault = channelFault[(k == 0) ? LIMP_CH_A : LIMP_CH_B];

         always_ff @(posedge ref_clk)
         begin
            if (rst || regClear)
            begin
               limpTrip[k] <= 1'b0;
               stage <= 2'h0;
               retryCnt <= 3'h0;
               timer <= '0;
               lowCnt <= '0;
            end
            else if (clkEn)
            begin
               // low long enough restarts the schedule; short dips are ignored
               if (pinS)
                  lowCnt <= '0;
               else if (lowCnt != LOWCNT_W'(LOW_RESET_CYCLES))
                  lowCnt <= lowCnt + 1'b1;
               if (!pinS && (lowCnt == LOWCNT_W'(LOW_RESET_CYCLES - 1)))
               begin
                  limpTrip[k] <= 1'b0;
                  stage <= 2'h0;
                  retryCnt <= 3'h0;
               end
               else if (limpTrip[k])
               begin
                  if (timer != '0)
                     timer <= timer - 1'b1;
                  else
                  begin
                     limpTrip[k] <= 1'b0;
                     if ((retryCnt == 3'(RETRIES_PER_STAGE - 1)) && (stage != LAST_STAGE))
                     begin
                        retryCnt <= 3'h0;
                        stage <= stage + 1'b1;
                     end
                     else if (stage != LAST_STAGE)
                        retryCnt <= retryCnt + 1'b1;
                  end
               end
               else if ((mode == MODE_LIMP) && pinS && fault && channelOn[(k == 0) ? LIMP_CH_A : LIMP_CH_B])
               begin
                  limpTrip[k] <= 1'b1;
                  timer <= TIMER_W'((RetryBaseCycles << stage) - 1);
               end
            end
         end
      end
   endgenerate

   // channel drive per mode
   assign activeOn = outEnable | (chanSel(mapA) & {8{inAS}}) | (chanSel(mapB) & {8{inBS}});
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         channelOn <= 8'h00;
      else if (clkEn)
      begin
         channelOn <= 8'h00;
         case (mode)
            MODE_ACTIVE:
               if (vsS)
                  channelOn <= activeOn & ~errFlag & ~latchClear;
            MODE_LIMP:
            begin
               // battery supply alone; logic supply plays no part here
               channelOn[LIMP_CH_A] <= vsS && inAS && !limpTrip[0];
               channelOn[LIMP_CH_B] <= vsS && inBS && !limpTrip[1];
            end
            default:
               channelOn <= 8'h00;
         endcase
      end
   end

   // open-load source only in active mode
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         openLoadSourceEn <= 8'h00;
      else if (clkEn)
         openLoadSourceEn <= (mode == MODE_ACTIVE) ? olConfig : 8'h00;
   end
endmodule
`default_nettype wire

// ---- verif/dmc_mode_ctrl_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module dmc_mode_ctrl_properties
#(
   parameter int unsigned RetryBaseCycles = 20
)
(
   input wire logic ref_clk, // clock
   input wire logic rst, // reset
   input wire logic idlePin, // idle pin
   input wire logic directInputA, // input a
   input wire logic directInputB, // input b
   input wire logic vsGood, // battery good
   input wire logic vddGood, // logic good
   input wire logic [7:0] channelFault, // trips
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic pslverr, // apb error
   input wire logic [7:0] channelOn, // drive
   input wire logic [7:0] openLoadSourceEn, // open-load source
   input wire dmc_pkg::dmc_mode_t mode // mode
);
   import dmc_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // pins held long enough for sync plus decode
   sequence limpPinsA; (!idlePin && directInputA && vsGood) [*5]; endsequence
   sequence activePinsB; (idlePin && directInputB && vsGood && vddGood) [*5]; endsequence
   sequence vddLost; (!vddGood) [*4]; endsequence
   logic tripped;
   logic [15:0] offCnt;
   // trip seen on channel 3 while its input stays high in limp
   always_ff @(posedge ref_clk)
   begin
      if (rst || !directInputB || mode != MODE_LIMP)
         tripped <= 1'b0;
      else if (channelOn[3] && channelFault[3])
         tripped <= 1'b1;
   end
   // off time of channel 3, saturating so it never wraps
   always_ff @(posedge ref_clk)
   begin
      if (rst || channelOn[3])
         offCnt <= 16'h0;
      else if (offCnt != 16'hffff)
         offCnt <= offCnt + 16'h1;
   end
   // drive lags mode by one edge, hence the past terms
   AST_SLEEP_OFF: assert property (mode == MODE_SLEEP && $past(mode) == MODE_SLEEP |-> channelOn == 8'h00)
      else $error("drive on in sleep");
   AST_IDLE_OFF: assert property (mode == MODE_IDLE && $past(mode) == MODE_IDLE
      |-> channelOn == 8'h00 && openLoadSourceEn == 8'h00) else $error("drive on in idle");
   AST_LIMP_ONLY_MID: assert property ($past(mode) == MODE_LIMP && mode == MODE_LIMP
      |-> (channelOn & 8'hf3) == 8'h00) else $error("limp drives other channel");
   AST_LIMP_NO_OL: assert property (mode == MODE_LIMP [*2] |-> openLoadSourceEn == 8'h00)
      else $error("open-load source on in limp");
   AST_LIMP_ENTRY: assert property (limpPinsA |-> mode == MODE_LIMP)
      else $error("limp not entered");
   AST_LIMP_A_DRIVE: assert property (limpPinsA ##1 (directInputA && !channelFault[2]) [*2]
      |-> channelOn[2]) else $error("channel 2 not driven");
   AST_ACTIVE_PIN: assert property (activePinsB |-> mode == MODE_ACTIVE)
      else $error("active not entered");
   AST_VDD_REFUSE: assert property (vddLost ##0 (psel && penable) |-> pslverr)
      else $error("access taken without logic supply");
   AST_LIMP_RO: assert property (mode == MODE_LIMP && psel && penable && pwrite |-> pslverr)
      else $error("write taken in limp");
   AST_RETRY_GAP: assert property ($rose(channelOn[3]) && tripped |-> offCnt >= RetryBaseCycles - 1)
      else $error("retry too early");
endmodule
bind dmc_mode_ctrl dmc_mode_ctrl_properties #(.RetryBaseCycles(RetryBaseCycles)) i_dmc_mode_ctrl_properties (
   .ref_clk(ref_clk), .rst(rst), .idlePin(idlePin), .directInputA(directInputA),
   .directInputB(directInputB), .vsGood(vsGood), .vddGood(vddGood), .channelFault(channelFault),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pslverr(pslverr), .channelOn(channelOn),
   .openLoadSourceEn(openLoadSourceEn), .mode(mode));
`default_nettype wire

// ---- verif/dmc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module dmc_host_model
(
   input wire logic ref_clk, // clock
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   output var logic psel, // select
   output var logic penable, // enable
   output var logic pwrite, // direction
   output var logic [7:0] paddr, // address
   output var logic [31:0] pwdata // write data
);
   // bus quiet from time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // request held until pready is seen; no fixed latency assumed
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // only the bench watchdog ends a wait that never sees pready
      do
      begin
         @(posedge ref_clk);
      end
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- verif/dmc_mode_ctrl_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module dmc_mode_ctrl_bench;
   import dmc_pkg::*;
   localparam int Base = 20;
   localparam logic [7:0] ACT_ADDR [4] = '{ADDR_HWCTRL, ADDR_OUTEN, ADDR_HWCTRL, ADDR_HWCTRL};
   localparam logic [31:0] ACT_DATA [4] = '{32'h1, 32'h1, 32'h2, 32'h4};
   logic ref_clk, rst, idlePin, directInputA, directInputB, vsGood, vddGood;
   logic openLoadOnDet, openLoadOffDet, frameError, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] channelFault, outputMonitor, paddr, channelOn, openLoadSourceEn;
   logic [31:0] pwdata, prdata, q;
   dmc_mode_t mode;
   int n_fail, total_checks, g;
   dmc_mode_ctrl #(.RetryBaseCycles(Base)) i_dmc_mode_ctrl (.ref_clk(ref_clk), .rst(rst), .clkEn(1'b1),
      .idlePin(idlePin), .directInputA(directInputA), .directInputB(directInputB), .vsGood(vsGood),
      .vddGood(vddGood), .channelFault(channelFault), .outputMonitor(outputMonitor),
      .openLoadOnDet(openLoadOnDet), .openLoadOffDet(openLoadOffDet), .frameError(frameError),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .channelOn(channelOn), .openLoadSourceEn(openLoadSourceEn),
      .mode(mode));
   dmc_host_model i_dmc_host_model (.ref_clk(ref_clk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   // 100 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_dmc_host_model.xfer(1'b1, a, d, q, err);
   endtask
   task automatic rd(input logic [7:0] a);
      i_dmc_host_model.xfer(1'b0, a, 32'h0, q, err);
   endtask
   // sync, decode and drive all land well inside six edges
   task automatic settle;
      repeat (6) @(posedge ref_clk);
      #1;
   endtask
   task automatic pins(input logic i, input logic a, input logic b);
      @(posedge ref_clk);
      idlePin <= i;
      directInputA <= a;
      directInputB <= b;
      settle;
   endtask
   // cycles up to the next turn-on of channel 3
   task automatic gap(output int c);
      c = 0;
      while (channelOn[3] === 1'b1 && c < 4000)
      begin
         @(posedge ref_clk);
         c++;
      end
      while (channelOn[3] !== 1'b1 && c < 4000)
      begin
         @(posedge ref_clk);
         c++;
      end
      chk("gapend", c < 4000, 1'b1);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // hang guard, far beyond the retry schedule length
   initial
   begin
      #200000;
      n_fail++;
      results;
   end
   initial
   begin
      {rst, vsGood, vddGood} = 3'h7;
      {idlePin, directInputA, directInputB, openLoadOnDet, openLoadOffDet, frameError} = 6'h0;
      channelFault = 8'h00;
      outputMonitor = 8'ha5;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      pins(1'b0, 1'b1, 1'b0);
      chk("mode", mode, MODE_LIMP);
      chk("drive", channelOn, 8'h04);
      pins(1'b0, 1'b0, 1'b0);
      chk("mode", mode, MODE_SLEEP);
      chk("drive", channelOn, 8'h00);
      $display("test power-up done");
      pins(1'b1, 1'b0, 1'b0);
      rd(ADDR_DIAG);
      chk("first", q, 32'h1);
      rd(ADDR_DIAG);
      chk("diag", q & 32'hf, 32'h7);
      rd(ADDR_DIAG);
      chk("diag", q & 32'hf, 32'h4);
      wr(ADDR_OLCFG, 32'hff);
      settle;
      chk("olsrc", openLoadSourceEn, 8'h00);
      for (int k = 0; k < 4; k++)
      begin
         wr(ACT_ADDR[k], ACT_DATA[k]);
         settle;
         chk("mode", mode, MODE_ACTIVE);
         wr(ACT_ADDR[k], 32'h0);
         settle;
         chk("mode", mode, MODE_IDLE);
      end
      wr(ADDR_OUTEN, 32'h1);
      settle;
      chk("drive", channelOn, 8'h01);
      channelFault <= 8'h01;
      @(posedge ref_clk);
      channelFault <= 8'h00;
      wr(ADDR_OUTEN, 32'h0);
      settle;
      rd(ADDR_DIAG);
      chk("err", q[15:8], 8'h01);
      wr(ADDR_LATCHCLR, 32'h1);
      settle;
      rd(ADDR_DIAG);
      chk("err", q[15:8], 8'h00);
      rd(ADDR_LATCHCLR);
      chk("lclr", q, 32'h0);
      wr(ADDR_MAP, 32'h54);
      rd(ADDR_MAP);
      chk("map", q, 32'h54);
      $display("test idle done");
      pins(1'b1, 1'b1, 1'b1);
      chk("mode", mode, MODE_ACTIVE);
      chk("drive", channelOn, 8'h0c);
      chk("olsrc", openLoadSourceEn, 8'hff);
      rd(ADDR_MAP);
      chk("map", q, 32'h32);
      {openLoadOnDet, openLoadOffDet} <= 2'h3;
      @(posedge ref_clk);
      {openLoadOnDet, openLoadOffDet} <= 2'h0;
      rd(ADDR_DIAG);
      chk("ol", q & 32'h60, 32'h60);
      // the diag read cleared them, so set them again before limp entry
      {openLoadOnDet, openLoadOffDet} <= 2'h3;
      @(posedge ref_clk);
      {openLoadOnDet, openLoadOffDet} <= 2'h0;
      pins(1'b0, 1'b1, 1'b1);
      chk("mode", mode, MODE_LIMP);
      chk("drive", channelOn, 8'h0c);
      chk("olsrc", openLoadSourceEn, 8'h00);
      rd(ADDR_MAP);
      chk("first", q, 32'h7);
      rd(ADDR_DIAG);
      chk("diag", q & 32'h73, 32'h3);
      wr(ADDR_MAP, 32'h0);
      chk("werr", err, 1'b1);
      rd(ADDR_MAP);
      chk("map", q, 32'h32);
      rd(ADDR_MONITOR);
      chk("mon", q, 32'ha5);
      $display("test limp done");
      channelFault <= 8'h08;
      gap(g);
      for (int k = 0; k < 7; k++)
      begin
         gap(g);
         chk("gap", g >= Base && g <= Base + 6, 1'b1);
      end
      gap(g);
      chk("gap", g >= 2 * Base && g <= 2 * Base + 6, 1'b1);
      directInputB <= 1'b0;
      repeat (LOW_RESET_CYCLES + 20) @(posedge ref_clk);
      directInputB <= 1'b1;
      gap(g);
      gap(g);
      chk("gap", g >= Base && g <= Base + 6, 1'b1);
      channelFault <= 8'h00;
      $display("test retry done");
      pins(1'b1, 1'b0, 1'b0);
      vddGood <= 1'b0;
      settle;
      rd(ADDR_DIAG);
      chk("verr", err, 1'b1);
      vsGood <= 1'b0;
      settle;
      chk("mode", mode, MODE_SLEEP);
      vsGood <= 1'b1;
      pins(1'b0, 1'b1, 1'b0);
      chk("mode", mode, MODE_LIMP);
      chk("drive", channelOn, 8'h04);
      $display("test supply done");
      results;
   end
endmodule
`default_nettype wire
